/* File: rtl/dcpb_consts.vh */
`ifndef DCPB_CONSTS_VH
`define DCPB_CONSTS_VH
// Register indices (byte map); Avalon byte address = index * 4
`define DCPB_REG_COUNT      24
`define DCPB_IDX_GLOBAL_A   20
`define DCPB_IDX_GLOBAL_B   21
`define DCPB_IDX_FIXED      22
`define DCPB_IDX_STATUS     23
// Fixed pattern of byte 22
`define DCPB_FIXED_VALUE    8'hA0
// Byte 20 fields
`define DCPB_MODE_HI        7
`define DCPB_MODE_LO        6
`define DCPB_CFG_BIT        5
`define DCPB_CFG_SRC_BIT    4
`define DCPB_OE1_BIT        3
`define DCPB_OE0_BIT        2
// Byte 21 fields
`define DCPB_INSEL_BIT      7
`define DCPB_POLICY_HI      6
`define DCPB_POLICY_LO      5
`define DCPB_RATE_HI        3
`define DCPB_RATE_LO        2
`define DCPB_WIN_HI         1
`define DCPB_WIN_LO         0
// Writable masks (reserved bits kept zero)
`define DCPB_MASK_GLOBAL_A  8'hFC
`define DCPB_MASK_GLOBAL_B  8'hEF
// Reset values of the global bytes
`define DCPB_RST_GLOBAL_A   8'h0C
`define DCPB_RST_GLOBAL_B   8'h08
// Mode codes
`define DCPB_MODE_LBW       2'b00
`define DCPB_MODE_SYN       2'b01
// Input selection policy codes
`define DCPB_POL_PIN        2'b00
`define DCPB_POL_REG        2'b11
// Edge window in microseconds per code, and core clock rate
`define DCPB_WIN_BASE_US    2
`define DCPB_CLK_MHZ        20
`define DCPB_WIN_BASE_CYC   (`DCPB_WIN_BASE_US * `DCPB_CLK_MHZ)
`endif

/* File: rtl/dcpb_byte_store.v */
`timescale 1ns/1ps
`default_nettype none
// Byte storage for the two configuration sets, read data registered
module dcpb_byte_store #(
  parameter DEPTH = 20,
  parameter AW    = 5
) (
  input  wire           ref_clk,   // Core clock
  input  wire           reset,     // Async reset, active high
  input  wire           wr_en,     // Write strobe
  input  wire [AW-1:0]  addr,      // Byte index
  input  wire [7:0]     wr_data,   // Write byte
  output reg  [7:0]     rd_data,   // Registered read byte
  output wire [8*DEPTH-1:0] flat   // All bytes, byte 0 lowest
);
  reg [7:0] mem_reg [0:DEPTH-1];
  integer i;
  genvar g;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_reg[i] <= 8'h00;
      rd_data <= 8'h00;
    end else begin
      if (wr_en && addr < DEPTH)
        mem_reg[addr] <= wr_data;
      rd_data <= (addr < DEPTH) ? mem_reg[addr] : 8'h00;
    end
  end

  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_flat
      assign flat[8*g +: 8] = mem_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: rtl/dcpb_pll_bank.v */
// Function
// - Selected set type bit 0 gives PECL style on first pair, 1 gives LVDS
// - Same encoding on second pair from the set's second type bit
// - Each set holds a 17-bit reference prescale value
// - Each set holds a 17-bit lower loop divisor
// - Each set holds 8-bit whole and 18-bit fraction upper loop divisor
// - Each set holds an 11-bit output divisor
// - Sets mean the same; only the selected set drives operation
// - Mode 00 low bandwidth, 01 synthesis, 10 and 11 high bandwidth
// - Set choice from pin when source bit 0, register bit when 1
// - Register set bit picks set, ignored unless source bit is 1
// - Pair enabled only when register enable and pin enable both high
// - Policy 00 pin manual, 01 auto nonrevertive, 10 revertive, 11 register
// - Input select picks input, names primary in auto, ignored in pin mode
// - Low bandwidth ADC rate is crystal divided by 16, 8, 4 or 2
// - Edge window is 2, 4, 8 or 16 microseconds for codes 00 to 11
// - Per input fault flag follows input state and is mirrored on pin
// - Crystal fault flag follows crystal state and is mirrored on pin
// - Lock flag reads 1 when locked and is mirrored on pin
// - Frozen tracking flag reads 1 in frozen_tracking_flag and is mirrored on pin
// - Active input bit follows fail-over and is mirrored on pin
// - Internal operation field decoded by mode into its subfields
// - Modulator enable 0 integer feedback, 1 fractional feedback
// - Modulator order 0 second order, 1 third order
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dcpb_consts.vh"
module dcpb_pll_bank (
  input  wire        ref_clk,               // Core clock, 20 MHz
  input  wire        reset,                 // Async reset, active high
  // Avalon-MM slave
  input  wire [6:0]  avs_address,           // Byte address
  input  wire        avs_read,              // Read request
  input  wire        avs_write,             // Write request
  input  wire [31:0] avs_writedata,         // Write data, low byte used
  input  wire [3:0]  avs_byteenable,        // Byte enables
  output reg  [31:0] avs_readdata,          // Read data
  output wire        avs_waitrequest,       // Stall
  output reg  [1:0]  avs_response,          // 00 ok, 10 slave error
  // Pins
  input  wire        config_select_pin,     // Set choice pin
  input  wire        first_output_enable,   // Enable pin, first pair
  input  wire        second_output_enable,  // Enable pin, second pair
  input  wire        input_select_pin,      // Manual input pin
  // Status from the PLL core
  input  wire        input_zero_fault,      // Input 0 bad
  input  wire        input_one_fault,       // Input 1 bad
  input  wire        crystal_fault,         // Crystal bad
  input  wire        pll_locked_flag,       // PLL locked
  input  wire        frozen_tracking_flag,  // Frozen_tracking_flag
  input  wire        active_input,          // Input in use
  // Status pins
  output reg         input_zero_fault_pin,  // Mirror
  output reg         input_one_fault_pin,   // Mirror
  output reg         crystal_fault_pin,     // Mirror
  output reg         pll_locked_pin,        // Mirror
  output reg         frozen_tracking_pin,   // Mirror
  output reg         active_input_pin,      // Mirror
  // Selected configuration to the analog core
  output reg         active_set,            // Set in use
  output reg         first_pair_signal_style,   // 0 PECL, 1 LVDS
  output reg         second_pair_signal_style,  // 0 PECL, 1 LVDS
  output reg         first_pair_on,         // First pair enabled
  output reg         second_pair_on,        // Second pair enabled
  output reg  [16:0] reference_prescale,    // Reference divider
  output reg  [16:0] lower_loop_divisor,    // Lower loop divider
  output reg  [7:0]  upper_loop_whole_part, // Upper divider integer
  output reg  [17:0] upper_loop_fraction_part, // Upper divider fraction
  output reg  [10:0] output_divisor,        // Output divider
  output reg  [6:0]  internal_operation_field, // Raw field of the set
  output reg  [1:0]  pll_mode,              // 00 low, 01 syn, 1x high
  output reg         high_bandwidth_mode,   // Decoded mode
  output reg         synthesis_mode,        // Decoded mode
  output reg  [1:0]  upper_loop_filter,     // Syn/high modes
  output reg         modulator_order,       // 0 second, 1 third
  output reg         modulator_enable,      // Fractional feedback on
  output reg  [1:0]  upper_pump_current,    // Syn/high modes
  output reg  [3:0]  adc_gain,              // Low bandwidth only
  output reg  [1:0]  lower_pump_current,    // Low bandwidth only
  output reg         reduced_pump_option,   // All modes
  output reg  [17:0] applied_fraction,      // Zero in integer mode
  output reg  [1:0]  input_selection_policy, // Selection policy
  output reg         selected_input,        // Input chosen
  output reg         primary_input,         // Primary in auto modes
  output reg  [4:0]  adc_rate_divisor,      // 16, 8, 4 or 2
  output reg  [11:0] edge_window_cycles     // Window in core cycles
);

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  reg [9:0] meta_reg;
  reg [9:0] sync_reg;
  wire [9:0] raw_pins = {config_select_pin, first_output_enable,
                         second_output_enable, input_select_pin,
                         input_zero_fault, input_one_fault, crystal_fault,
                         pll_locked_flag, frozen_tracking_flag,
                         active_input};
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 10'h000;
      sync_reg <= 10'h000;
    end else begin
      meta_reg <= raw_pins;
      sync_reg <= meta_reg;
    end
  end
  wire cfg_pin_s  = sync_reg[9];
  wire oe0_pin_s  = sync_reg[8];
  wire oe1_pin_s  = sync_reg[7];
  wire insel_s    = sync_reg[6];
  wire [5:0] stat_s = sync_reg[5:0];

  // -----------------------------------------------------------------
  // Bus slave: reads wait two cycles for the registered store
  // -----------------------------------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_DONE  = 3'b100;
  reg [2:0] state_reg;
  reg [2:0] state_next;

  wire [4:0] idx      = avs_address[6:2];
  wire       mapped   = (avs_address[6:2] < `DCPB_REG_COUNT) &&
                        (avs_address[1:0] == 2'b00);
  wire       low_lane = avs_byteenable[0];
  wire       is_cfg   = idx < `DCPB_IDX_GLOBAL_A;
  wire       wr_take  = avs_write && state_reg == ST_IDLE;
  wire       store_we = wr_take && mapped && is_cfg && low_lane;
  wire [7:0] wbyte    = avs_writedata[7:0];

  always @* begin
    case (state_reg)
      ST_IDLE:  state_next = avs_read ? ST_FETCH : ST_IDLE;
      ST_FETCH: state_next = ST_DONE;
      default: state_next = ST_IDLE;
    endcase
  end
  assign avs_waitrequest = avs_read && state_reg != ST_DONE;

  always @(posedge ref_clk or posedge reset) begin
    if (reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // -----------------------------------------------------------------
  // Configuration set storage, bytes 0 to 19
  // -----------------------------------------------------------------
  wire [7:0]   store_rd;
  wire [159:0] cfg_flat;
  dcpb_byte_store #(.DEPTH(20), .AW(5)) u_store (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (store_we),
    .addr    (idx),
    .wr_data (wbyte),
    .rd_data (store_rd),
    .flat    (cfg_flat)
  );

  // -----------------------------------------------------------------
  // Global control bytes
  // -----------------------------------------------------------------
  reg [7:0] glob_a_reg;
  reg [7:0] glob_b_reg;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      glob_a_reg <= `DCPB_RST_GLOBAL_A;
      glob_b_reg <= `DCPB_RST_GLOBAL_B;
    end else if (wr_take && mapped && low_lane) begin
      // Reserved bits masked so they always read zero
      if (idx == `DCPB_IDX_GLOBAL_A)
        glob_a_reg <= wbyte & `DCPB_MASK_GLOBAL_A;
      if (idx == `DCPB_IDX_GLOBAL_B)
        glob_b_reg <= wbyte & `DCPB_MASK_GLOBAL_B;
    end
  end

  // Status byte is built from pins only; writes never reach it
  wire [7:0] status_byte = {stat_s[0], stat_s[1], stat_s[4], stat_s[5],
                            stat_s[3], stat_s[2], 2'b00};

  // -----------------------------------------------------------------
  // Read data and response
  // -----------------------------------------------------------------
  reg [4:0] rd_idx_reg;
  reg       rd_ok_reg;
  reg [7:0] rd_byte;
  always @* begin
    case (rd_idx_reg)
      `DCPB_IDX_GLOBAL_A: rd_byte = glob_a_reg;
      `DCPB_IDX_GLOBAL_B: rd_byte = glob_b_reg;
      `DCPB_IDX_FIXED:    rd_byte = `DCPB_FIXED_VALUE;
      `DCPB_IDX_STATUS:   rd_byte = status_byte;
      default:            rd_byte = store_rd;
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_idx_reg   <= 5'h00;
      rd_ok_reg    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else begin
      if (state_reg == ST_IDLE && avs_read) begin
        rd_idx_reg <= idx;
        rd_ok_reg  <= mapped;
      end
      if (wr_take)
        avs_response <= mapped ? 2'b00 : 2'b10;
      if (state_reg == ST_FETCH) begin
        avs_readdata <= rd_ok_reg ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        avs_response <= rd_ok_reg ? 2'b00 : 2'b10;
      end
    end
  end

  // -----------------------------------------------------------------
  // Set selection and field extraction
  // -----------------------------------------------------------------
  wire set_sel = glob_a_reg[`DCPB_CFG_SRC_BIT] ?
                 glob_a_reg[`DCPB_CFG_BIT] : cfg_pin_s;
  // Byte b of the selected set: set 0 uses even, set 1 odd indices
  function [7:0] sb;
    input [159:0] f;
    input [3:0]   b;
    input         s;
    begin
      sb = f[8*({b, 1'b0} + s) +: 8];
    end
  endfunction

  wire [7:0] b0 = sb(cfg_flat, 4'd0, set_sel);
  wire [7:0] b1 = sb(cfg_flat, 4'd1, set_sel);
  wire [7:0] b2 = sb(cfg_flat, 4'd2, set_sel);
  wire [7:0] b3 = sb(cfg_flat, 4'd3, set_sel);
  wire [7:0] b4 = sb(cfg_flat, 4'd4, set_sel);
  wire [7:0] b5 = sb(cfg_flat, 4'd5, set_sel);
  wire [7:0] b6 = sb(cfg_flat, 4'd6, set_sel);
  wire [7:0] b7 = sb(cfg_flat, 4'd7, set_sel);
  wire [7:0] b8 = sb(cfg_flat, 4'd8, set_sel);
  wire [7:0] b9 = sb(cfg_flat, 4'd9, set_sel);

  wire [17:0] frac_w  = {b0, b1, b2[7:6]};
  wire [7:0]  whole_w = {b2[5:0], b3[7:6]};
  wire [16:0] pre_w   = {b3[5:0], b4, b5[7:5]};
  wire [16:0] low_w   = {b5[4:0], b6, b7[7:4]};
  wire [10:0] out_w   = {b7[3:0], b8[7:1]};
  wire [6:0]  iop_w   = {b8[0], b9[7:2]};
  wire [1:0]  mode_w  = glob_a_reg[`DCPB_MODE_HI:`DCPB_MODE_LO];
  wire        lbw_w   = mode_w == `DCPB_MODE_LBW;
  wire [1:0]  pol_w   = glob_b_reg[`DCPB_POLICY_HI:`DCPB_POLICY_LO];
  wire [1:0]  rate_w  = glob_b_reg[`DCPB_RATE_HI:`DCPB_RATE_LO];
  wire [1:0]  win_w   = glob_b_reg[`DCPB_WIN_HI:`DCPB_WIN_LO];
  wire        insel_r = glob_b_reg[`DCPB_INSEL_BIT];
  localparam integer WIN_CYC = `DCPB_WIN_BASE_CYC;

  // -----------------------------------------------------------------
  // Registered outputs to the core
  // -----------------------------------------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      active_set               <= 1'b0;
      first_pair_signal_style  <= 1'b0;
      second_pair_signal_style <= 1'b0;
      first_pair_on            <= 1'b0;
      second_pair_on           <= 1'b0;
      reference_prescale       <= 17'h0_0000;
      lower_loop_divisor       <= 17'h0_0000;
      upper_loop_whole_part    <= 8'h00;
      upper_loop_fraction_part <= 18'h0_0000;
      output_divisor           <= 11'h000;
      internal_operation_field <= 7'h00;
      pll_mode                 <= 2'b00;
      high_bandwidth_mode      <= 1'b0;
      synthesis_mode           <= 1'b0;
      upper_loop_filter        <= 2'b00;
      modulator_order          <= 1'b0;
      modulator_enable         <= 1'b0;
      upper_pump_current       <= 2'b00;
      adc_gain                 <= 4'h0;
      lower_pump_current       <= 2'b00;
      reduced_pump_option      <= 1'b0;
      applied_fraction         <= 18'h0_0000;
      input_selection_policy   <= 2'b00;
      selected_input           <= 1'b0;
      primary_input            <= 1'b0;
      adc_rate_divisor         <= 5'h10;
      edge_window_cycles       <= 12'h000;
      input_zero_fault_pin     <= 1'b0;
      input_one_fault_pin      <= 1'b0;
      crystal_fault_pin        <= 1'b0;
      pll_locked_pin           <= 1'b0;
      frozen_tracking_pin      <= 1'b0;
      active_input_pin         <= 1'b0;
    end else begin
      active_set               <= set_sel;
      first_pair_signal_style  <= b9[0];
      second_pair_signal_style <= b9[1];
      first_pair_on  <= glob_a_reg[`DCPB_OE0_BIT] & oe0_pin_s;
      second_pair_on <= glob_a_reg[`DCPB_OE1_BIT] & oe1_pin_s;
      reference_prescale       <= pre_w;
      lower_loop_divisor       <= low_w;
      upper_loop_whole_part    <= whole_w;
      upper_loop_fraction_part <= frac_w;
      output_divisor           <= out_w;
      internal_operation_field <= iop_w;
      pll_mode            <= mode_w;
      high_bandwidth_mode <= mode_w[1];
      synthesis_mode      <= mode_w == `DCPB_MODE_SYN;
      // Loop two fields fall back to defaults in low bandwidth
      upper_loop_filter   <= lbw_w ? 2'b00 : iop_w[6:5];
      modulator_order     <= lbw_w ? 1'b0  : iop_w[4];
      modulator_enable    <= lbw_w ? 1'b0  : iop_w[3];
      upper_pump_current  <= lbw_w ? 2'b00 : iop_w[2:1];
      adc_gain            <= lbw_w ? iop_w[6:3] : 4'h0;
      lower_pump_current  <= lbw_w ? iop_w[2:1] : 2'b00;
      reduced_pump_option <= iop_w[0];
      applied_fraction    <= (!lbw_w && iop_w[3]) ?
                             frac_w : 18'h0_0000;
      input_selection_policy <= pol_w;
      // Auto policies hand the primary to the core's fail-over logic
      case (pol_w)
        `DCPB_POL_PIN: selected_input <= insel_s;
        `DCPB_POL_REG: selected_input <= insel_r;
        default:       selected_input <= insel_r;
      endcase
      primary_input    <= insel_r;
      adc_rate_divisor <= 5'h10 >> rate_w;
      edge_window_cycles <= WIN_CYC[11:0] << win_w;
      input_zero_fault_pin <= stat_s[5];
      input_one_fault_pin  <= stat_s[4];
      crystal_fault_pin    <= stat_s[3];
      pll_locked_pin       <= stat_s[2];
      frozen_tracking_pin  <= stat_s[1];
      active_input_pin     <= stat_s[0];
    end
  end
endmodule
`default_nettype wire

/* File: dv/dcpb_pll_bank_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dcpb_pll_bank_props (
  input wire logic        ref_clk,                  // Core clock
  input wire logic        reset,                    // Async reset
  input wire logic        avs_read,                 // Read request
  input wire logic        avs_waitrequest,          // Stall
  input wire logic        crystal_fault,            // Crystal bad
  input wire logic        crystal_fault_pin,        // Mirror
  input wire logic        pll_locked_flag,          // Locked
  input wire logic        pll_locked_pin,           // Mirror
  input wire logic        input_one_fault,          // Input 1 bad
  input wire logic        input_one_fault_pin,      // Mirror
  input wire logic        first_output_enable,      // Enable pin
  input wire logic        first_pair_on,            // Pair state
  input wire logic [1:0]  pll_mode,                 // Mode code
  input wire logic        high_bandwidth_mode,      // Decoded
  input wire logic        synthesis_mode,           // Decoded
  input wire logic [1:0]  upper_loop_filter,        // Loop two
  input wire logic        modulator_enable,         // Fraction on
  input wire logic [1:0]  upper_pump_current,       // Loop two
  input wire logic [17:0] applied_fraction,         // Applied
  input wire logic [17:0] upper_loop_fraction_part, // Stored
  input wire logic [11:0] edge_window_cycles        // Window
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Reads stall two cycles
  property p_wait_read;
    $rose(avs_read) |-> avs_waitrequest [*2] ##1 !avs_waitrequest;
  endproperty
  a_wait_read: assert property (p_wait_read) else $error("read wait");
  property p_xtal;
    crystal_fault_pin != crystal_fault |-> ##[1:4]
      crystal_fault_pin == crystal_fault;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal mirror");
  property p_lock;
    $rose(pll_locked_flag) |-> ##[1:4] pll_locked_pin;
  endproperty
  a_lock: assert property (p_lock) else $error("lock mirror");
  property p_in1;
    input_one_fault [*5] |-> input_one_fault_pin;
  endproperty
  a_in1: assert property (p_in1) else $error("fault mirror");
  property p_oe;
    !first_output_enable [*5] |-> !first_pair_on;
  endproperty
  a_oe: assert property (p_oe) else $error("pair on");
  property p_mode;
    high_bandwidth_mode == pll_mode[1] &&
      synthesis_mode == (pll_mode == 2'b01);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode");
  property p_lbw;
    pll_mode == 2'b00 |-> upper_loop_filter == 2'b00 &&
      !modulator_enable && upper_pump_current == 2'b00;
  endproperty
  a_lbw: assert property (p_lbw) else $error("low bw decode");
  property p_frac;
    applied_fraction ==
      (modulator_enable ? upper_loop_fraction_part : 18'h0_0000);
  endproperty
  a_frac: assert property (p_frac) else $error("fraction");
  property p_window;
    !$past(reset) |->
      edge_window_cycles inside {12'h028, 12'h050, 12'h0a0, 12'h140};
  endproperty
  a_window: assert property (p_window) else $error("window");
  cover property (high_bandwidth_mode && modulator_enable);
  cover property ($rose(crystal_fault_pin));
  cover property ($rose(first_pair_on));
endmodule
bind dcpb_pll_bank dcpb_pll_bank_props props_u (.*);
`default_nettype wire

/* File: dv/dcpb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus host; holds each request until waitrequest is low
module dcpb_host_model (
  input  wire logic        ref_clk,         // Core clock
  output logic      [6:0]  avs_address,     // Byte address
  output logic             avs_read,        // Read request
  output logic             avs_write,       // Write request
  output logic      [31:0] avs_writedata,   // Write data
  output logic      [3:0]  avs_byteenable,  // Byte enables
  input  wire logic [31:0] avs_readdata,    // Read data
  input  wire logic        avs_waitrequest, // Stall
  input  wire logic [1:0]  avs_response     // Response
);
  initial begin
    avs_address = 7'h00;
    {avs_read, avs_write} = 2'b00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == 7'h50) ? (d & 8'hfc) : d;
    if (a == 7'h54) v = v & 8'hef;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, v};
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest);
    d = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: dv/dcpb_pll_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dcpb_pll_bank_test;
  logic        ref_clk, reset, config_select_pin, input_select_pin;
  logic        first_output_enable, second_output_enable, active_input;
  logic        input_zero_fault, input_one_fault, crystal_fault;
  logic        pll_locked_flag, frozen_tracking_flag, avs_read, avs_write;
  logic        avs_waitrequest, input_zero_fault_pin, input_one_fault_pin;
  logic        crystal_fault_pin, pll_locked_pin, frozen_tracking_pin;
  logic        active_input_pin, active_set, first_pair_signal_style;
  logic        second_pair_signal_style, first_pair_on, second_pair_on;
  logic        high_bandwidth_mode, synthesis_mode, modulator_order;
  logic        modulator_enable, reduced_pump_option, selected_input;
  logic        primary_input;
  logic [6:0]  avs_address, internal_operation_field, bw;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [3:0]  avs_byteenable, adc_gain;
  logic [1:0]  avs_response, pll_mode, upper_loop_filter, rr;
  logic [1:0]  upper_pump_current, lower_pump_current, input_selection_policy;
  logic [16:0] reference_prescale, lower_loop_divisor;
  logic [7:0]  upper_loop_whole_part;
  logic [17:0] upper_loop_fraction_part, applied_fraction;
  logic [10:0] output_divisor;
  logic [4:0]  adc_rate_divisor;
  logic [11:0] edge_window_cycles;
  logic [7:0]  m [0:19];
  int          err_total, n_checks;
  dcpb_pll_bank dut_u (.*);
  dcpb_host_model host_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [6:0] ad(int i);
    return 7'(i * 4);
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_set(int s);
    chk(active_set, s);
    chk(reference_prescale, {m[6+s][5:0], m[8+s], m[10+s][7:5]});
    chk(lower_loop_divisor, {m[10+s][4:0], m[12+s], m[14+s][7:4]});
    chk(upper_loop_whole_part, {m[4+s][5:0], m[6+s][7:6]});
    chk(upper_loop_fraction_part, {m[s], m[2+s], m[4+s][7:6]});
    chk(output_divisor, {m[14+s][3:0], m[16+s][7:1]});
    chk(internal_operation_field, {m[16+s][0], m[18+s][7:2]});
    chk(first_pair_signal_style, m[18+s][0]);
    chk(second_pair_signal_style, m[18+s][1]);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    err_total = 0;
    n_checks = 0;
    reset = 1'b1;
    {config_select_pin, input_select_pin, active_input} = 3'b000;
    {first_output_enable, second_output_enable} = 2'b11;
    {input_zero_fault, input_one_fault, crystal_fault} = 3'b000;
    {pll_locked_flag, frozen_tracking_flag} = 2'b00;
    cyc(10);
    reset <= 1'b0;
    host_u.rd(ad(20), rv, rr);
    chk(rv, 32'h0000_000c);
    host_u.rd(ad(21), rv, rr);
    chk(rv, 32'h0000_0008);
    chk(adc_rate_divisor, 5'h04);
    chk(edge_window_cycles, 12'h028);
    $display("defaults done");
    for (int i = 0; i < 20; i++) begin
      m[i] = 8'(i * 59 + 21);
      host_u.wr(ad(i), m[i]);
    end
    host_u.rd(ad(19), rv, rr);
    chk(rv, {24'h00_0000, m[19]});
    for (int s = 0; s < 2; s++) begin
      host_u.wr(ad(20), 8'(s * 32 + 28));
      cyc(3);
      chk_set(s);
    end
    // Set bit ignored while the pin is in charge
    host_u.wr(ad(20), 8'h2c);
    cyc(5);
    chk(active_set, 1'b0);
    config_select_pin <= 1'b1;
    cyc(5);
    chk_set(1);
    $display("set selection done");
    bw = {m[17][0], m[19][7:2]};
    for (int md = 0; md < 4; md++) begin
      host_u.wr(ad(20), 8'(md * 64 + 60));
      cyc(3);
      chk(pll_mode, md);
      chk(high_bandwidth_mode, md >= 2);
      chk(synthesis_mode, md == 1);
      chk(reduced_pump_option, bw[0]);
      chk(adc_gain, md == 0 ? bw[6:3] : 4'h0);
      chk(lower_pump_current, md == 0 ? bw[2:1] : 2'h0);
      chk(upper_loop_filter, md == 0 ? 2'h0 : bw[6:5]);
      chk(upper_pump_current, md == 0 ? 2'h0 : bw[2:1]);
      chk(modulator_order, md == 0 ? 1'b0 : bw[4]);
      chk(modulator_enable, md == 0 ? 1'b0 : bw[3]);
      chk(applied_fraction, (md != 0 && bw[3]) ?
          {m[1], m[3], m[5][7:6]} : 18'h0_0000);
    end
    $display("mode decode done");
    for (int k = 0; k < 16; k++) begin
      host_u.wr(ad(20), 8'(k % 4 * 4 + 48));
      {second_output_enable, first_output_enable} <= 2'(k / 4);
      cyc(5);
      chk(first_pair_on, k % 2 == 1 && (k / 4) % 2 == 1);
      chk(second_pair_on, (k / 2) % 2 == 1 && k / 8 == 1);
    end
    $display("output enable done");
    for (int c = 0; c < 4; c++) begin
      for (int q = 0; q < 2; q++) begin
        input_select_pin <= (q == 0);
        host_u.wr(ad(21), 8'(q * 128 + c * 32 + c * 4 + c));
        cyc(5);
        chk(input_selection_policy, c);
        chk(selected_input, c == 0 ? (q == 0) : (q == 1));
        if (c == 1 || c == 2) chk(primary_input, q);
        chk(adc_rate_divisor, 16 >> c);
        chk(edge_window_cycles, 40 << c);
        host_u.rd(ad(21), rv, rr);
        chk(rv, q * 128 + c * 32 + c * 4 + c);
      end
    end
    $display("input policy done");
    for (int b = 0; b < 6; b++) begin
      {active_input, frozen_tracking_flag, input_one_fault,
       input_zero_fault, crystal_fault, pll_locked_flag} <= 6'(1 << b);
      cyc(5);
      host_u.wr(ad(23), 8'hff);
      host_u.rd(ad(23), rv, rr);
      chk(rv, 4 << b);
      chk({active_input_pin, frozen_tracking_pin, input_one_fault_pin,
           input_zero_fault_pin, crystal_fault_pin,
           pll_locked_pin}, 1 << b);
    end
    $display("status done");
    host_u.rd(7'h60, rv, rr);
    chk(rv, 32'h0000_0000);
    chk(rr, 2'h2);
    host_u.rd(7'h51, rv, rr);
    chk(rr, 2'h2);
    host_u.rd(ad(22), rv, rr);
    chk(rv, 32'h0000_00a0);
    $display("address map done");
    wrap_up();
  end
  // Tests need well under 1200 cycles
  initial begin
    cyc(6000);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
